// ---- logic/image_checksum_pkg.sv ----
// Constants, mask tables, carrier structs and register map for the image checksum engine.
// Assumes a single 100 MHz clock domain and an AXI4-Lite master reaching the registers.
package image_checksum_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] STATUS_OFFSET     = 8'h04;
  localparam logic [7:0] CHECKSUM_OFFSET   = 8'h08;
  localparam logic [7:0] PF_SUM_OFFSET     = 8'h0C;
  localparam logic [7:0] BF_SUM_OFFSET     = 8'h10;
  localparam logic [7:0] CFG_SUM_OFFSET    = 8'h14;
  localparam logic [7:0] ID_SUM_OFFSET     = 8'h18;
  localparam logic [7:0] PF_WORDS_OFFSET   = 8'h1C;
  localparam logic [7:0] BF_WORDS_OFFSET   = 8'h20;
  localparam logic [7:0] CFG0_OFFSET       = 8'h24;

  // Control and status field positions.
  localparam int CTRL_START_BIT    = 0;
  localparam int CTRL_VARIANT_LSB  = 4;
  localparam int STATUS_BUSY_BIT   = 0;
  localparam int STATUS_DONE_BIT   = 1;
  localparam int STATUS_PROT_BIT   = 2;

  // Configuration word zero field positions.
  localparam int CODE_PROTECT_BIT         = 28;
  localparam int BOOT_WRITE_PROTECT_BIT   = 24;
  localparam int PWP_FIELD_MSB            = 19;
  localparam int PWP_FIELD_LSB            = 12;
  localparam int DEBUG_CHANNEL_SELECT_BIT = 3;
  localparam int DEBUGGER_FIELD_MSB       = 1;

  // Reset values and defaults.
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [31:0] ERASED_WORD      = 32'hFFFF_FFFF;
  localparam logic [31:0] PF_WORDS_RESET   = 32'h0002_0000;
  localparam logic [31:0] BF_WORDS_RESET   = 32'h0000_0C00;
  localparam logic [31:0] CFG0_DEFAULT     = 32'h7FFF_FFFF;
  localparam int          CFG_WORD_COUNT   = 4;
  localparam int          VARIANT_COUNT    = 4;

  // Five masks of one device variant.
  typedef struct packed {
    logic [31:0] id_mask;
    logic [31:0] cfg3_mask;
    logic [31:0] cfg2_mask;
    logic [31:0] cfg1_mask;
    logic [31:0] cfg0_mask;
  } mask_set_t;

  // Mask table indexed by the variant select; index 2 is the reference variant.
  localparam mask_set_t MASK_TABLE [VARIANT_COUNT] = '{
    '{32'h0FFF_F000, 32'hF0C0_FFFF, 32'h0007_8777, 32'h03DF_F7A7, 32'h1100_FC1F},
    '{32'h0FFF_F000, 32'hC407_FFFF, 32'h0007_8777, 32'h009F_F7A7, 32'h110F_F00F},
    '{32'h000F_F000, 32'h0000_FFFF, 32'h0007_0077, 32'h009F_F7A7, 32'h110F_F00B},
    '{32'h000F_F000, 32'h0000_FFFF, 32'h0007_8777, 32'h009F_F7A7, 32'h110F_F00B}
  };

  // One memory word tagged with the region it came from.
  typedef enum logic [1:0] {
    REGION_PROGRAM,
    REGION_BOOT,
    REGION_CONFIG,
    REGION_IDENT
  } region_t;

  typedef struct packed {
    region_t     region;
    logic [1:0]  cfg_index;
    logic [31:0] data;
  } mem_word_t;

  localparam int MEM_WORD_WIDTH = $bits(mem_word_t);
  localparam int FIFO_DEPTH     = 32;

  // Sum of the four unsigned bytes of a word.
  function automatic logic [31:0] byte_sum(input logic [31:0] w);
    byte_sum = {24'h000000, w[7:0]} + {24'h000000, w[15:8]} +
               {24'h000000, w[23:16]} + {24'h000000, w[31:24]};
  endfunction

endpackage

// ---- logic/word_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
// Assumes writer and reader share one clock and an asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  // Full and empty come from pointers with one extra wrap bit.
  assign in_ready_out  = (wr_ptr_r - rd_ptr_r) != (AW + 1)'(DEPTH);
  assign out_valid_out = wr_ptr_r != rd_ptr_r;
  assign out_data_out  = mem[rd_ptr_r[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Storage array is written without reset.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers advance on each accepted handshake.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

// ---- logic/memory_image_checksum.sv ----
// Image checksum engine: walks both flashes, masked configuration and identifier words.
// Assumes flash read ports answer in the same cycle as the registered address and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module memory_image_checksum (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Memory read port, one word per address, data taken in the same cycle as the address.
  output logic [31:0]      mem_addr_out,
  output logic             mem_rd_out,
  output image_checksum_pkg::region_t mem_region_out,
  input  wire logic [31:0] mem_rdata_in,
  input  wire logic [31:0] device_identifier_word_in,
  input  wire logic [1:0]  variant_in
);
  import image_checksum_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_PROG, ST_BOOT, ST_CFG, ST_IDENT, ST_DRAIN} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [31:0] addr;
    logic        rd_pend;
    region_t     rd_region;
    logic [1:0]  rd_cfg;
    logic [1:0]  variant;
    logic [31:0] pf_sum;
    logic [31:0] bf_sum;
    logic [31:0] cfg_sum;
    logic [31:0] id_sum;
    logic [31:0] checksum;
    logic [31:0] config_word_zero;
    logic        done;
    logic        protect;
    logic [31:0] pf_words;
    logic [31:0] bf_words;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  awaddr;
    logic        aw_got;
    logic [31:0] wdata;
    logic        w_got;
    logic [31:0] mem_addr;
    logic        mem_rd;
    region_t     mem_region;
  } state_t;

  state_t    s_r;
  state_t    s_nxt;
  mem_word_t fifo_in;
  mem_word_t fifo_out;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  mask_set_t masks;
  logic      busy;
  logic      do_write;
  logic      do_read;
  logic [31:0] masked;
  logic [31:0] total;

  // Words read from memory are queued; the accumulator pops one every cycle, so the walker never stalls.
  word_fifo #(.WIDTH(MEM_WORD_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_data_in    (fifo_in),
    .in_valid_in   (s_r.rd_pend),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (fifo_out),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (1'b1)
  );

  // Queue entry built from the word returned for the previous address.
  always_comb begin
    fifo_in.region    = s_r.rd_region;
    fifo_in.cfg_index = s_r.rd_cfg;
    fifo_in.data      = (s_r.rd_region == REGION_IDENT) ? device_identifier_word_in : mem_rdata_in;
  end

  assign masks    = MASK_TABLE[s_r.variant];
  assign busy     = s_r.phase != ST_IDLE;
  assign do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign do_read  = s_axi_arvalid_in && s_r.arready;
  assign total    = s_r.pf_sum + s_r.bf_sum + s_r.cfg_sum + s_r.id_sum;

  // Mask a queued word by its region and index.
  always_comb begin
    masked = fifo_out.data;
    if (fifo_out.region == REGION_CONFIG) begin
      unique case (fifo_out.cfg_index)
        2'd0: masked = fifo_out.data & masks.cfg0_mask;
        2'd1: masked = fifo_out.data & masks.cfg1_mask;
        2'd2: masked = fifo_out.data & masks.cfg2_mask;
        2'd3: masked = fifo_out.data & masks.cfg3_mask;
      endcase
    end else if (fifo_out.region == REGION_IDENT) begin
      masked = fifo_out.data & masks.id_mask;
    end
  end

  // Next-state logic for walker, accumulators and bus slave.
  always_comb begin
    s_nxt         = s_r;
    s_nxt.rd_pend = 1'b0;
    s_nxt.mem_rd  = 1'b0;
    // Walker issues one read per cycle while the queue has room.
    if (fifo_in_ready) begin
      unique case (s_r.phase)
        ST_IDLE: begin
        end
        ST_PROG: begin
          if (s_r.addr == s_r.pf_words) begin
            s_nxt.phase = ST_BOOT;
            s_nxt.addr  = ZERO_WORD;
          end else begin
            s_nxt.mem_rd = 1'b1;
            s_nxt.mem_region = REGION_PROGRAM;
            s_nxt.mem_addr   = s_r.addr;
            s_nxt.rd_pend    = 1'b1;
            s_nxt.rd_region  = REGION_PROGRAM;
            s_nxt.addr       = s_r.addr + 32'h1;
          end
        end
        ST_BOOT, ST_CFG: begin
          if (s_r.addr == s_r.bf_words) begin
            s_nxt.phase = ST_IDENT;
          end else begin
            s_nxt.mem_rd     = 1'b1;
            s_nxt.mem_region = REGION_BOOT;
            s_nxt.mem_addr   = s_r.addr;
            s_nxt.rd_pend    = 1'b1;
            // Last four boot words are configuration words, highest is word zero.
            s_nxt.rd_region  = (s_r.addr >= s_r.bf_words - CFG_WORD_COUNT) ?
                               REGION_CONFIG : REGION_BOOT;
            s_nxt.rd_cfg     = 2'(s_r.bf_words - 32'h1 - s_r.addr);
            s_nxt.addr       = s_r.addr + 32'h1;
          end
        end
        ST_IDENT: begin
          s_nxt.rd_pend   = 1'b1;
          s_nxt.rd_region = REGION_IDENT;
          s_nxt.phase     = ST_DRAIN;
        end
        ST_DRAIN: begin
          if (!fifo_out_valid && !s_r.rd_pend) begin
            s_nxt.phase    = ST_IDLE;
            s_nxt.done     = 1'b1;
            // Protected image reports zero; otherwise two's complement of the total.
            s_nxt.protect  = !s_r.config_word_zero[CODE_PROTECT_BIT];
            s_nxt.checksum = s_nxt.protect ? ZERO_WORD : (~total + 32'h1);
          end
        end
      endcase
    end
    // Accumulate each popped word into its own region sum.
    if (fifo_out_valid) begin
      unique case (fifo_out.region)
        REGION_PROGRAM: s_nxt.pf_sum  = s_r.pf_sum + byte_sum(masked);
        REGION_BOOT:    s_nxt.bf_sum  = s_r.bf_sum + byte_sum(masked);
        REGION_CONFIG:  s_nxt.cfg_sum = s_r.cfg_sum + byte_sum(masked);
        REGION_IDENT:   s_nxt.id_sum  = s_r.id_sum + byte_sum(masked);
      endcase
      if (fifo_out.region == REGION_CONFIG && fifo_out.cfg_index == 2'd0) begin
        s_nxt.config_word_zero = fifo_out.data;
      end
    end
    // Write address and data are taken in either order.
    if (s_axi_awvalid_in && s_r.awready) begin
      s_nxt.awaddr  = s_axi_awaddr_in;
      s_nxt.aw_got  = 1'b1;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid_in && s_r.wready) begin
      s_nxt.wdata  = s_axi_wdata_in;
      s_nxt.w_got  = 1'b1;
      s_nxt.wready = 1'b0;
    end
    if (do_write) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = 2'b00;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      unique case (s_r.awaddr)
        CTRL_OFFSET: begin
          if (s_r.wdata[CTRL_START_BIT] && !busy) begin
            s_nxt.phase   = ST_PROG;
            s_nxt.addr    = ZERO_WORD;
            s_nxt.variant = s_r.wdata[CTRL_VARIANT_LSB +: 2];
            s_nxt.pf_sum  = ZERO_WORD;
            s_nxt.bf_sum  = ZERO_WORD;
            s_nxt.cfg_sum = ZERO_WORD;
            s_nxt.id_sum  = ZERO_WORD;
            s_nxt.done    = 1'b0;
          end
        end
        PF_WORDS_OFFSET: s_nxt.pf_words = busy ? s_r.pf_words : s_r.wdata;
        BF_WORDS_OFFSET: s_nxt.bf_words = busy ? s_r.bf_words : s_r.wdata;
        default:         s_nxt.bresp    = 2'b10;
      endcase
    end
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end
    // Read channel: one cycle from address to data.
    if (do_read) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = 2'b00;
      unique case (s_axi_araddr_in)
        CTRL_OFFSET:     s_nxt.rdata = {26'h0, s_r.variant, 4'h0};
        STATUS_OFFSET:   s_nxt.rdata = {29'h0, s_r.protect, s_r.done, busy};
        CHECKSUM_OFFSET: s_nxt.rdata = s_r.checksum;
        PF_SUM_OFFSET:   s_nxt.rdata = s_r.pf_sum;
        BF_SUM_OFFSET:   s_nxt.rdata = s_r.bf_sum;
        CFG_SUM_OFFSET:  s_nxt.rdata = s_r.cfg_sum;
        ID_SUM_OFFSET:   s_nxt.rdata = s_r.id_sum;
        PF_WORDS_OFFSET: s_nxt.rdata = s_r.pf_words;
        BF_WORDS_OFFSET: s_nxt.rdata = s_r.bf_words;
        CFG0_OFFSET:     s_nxt.rdata = s_r.config_word_zero;
        default: begin
          s_nxt.rdata = ZERO_WORD;
          s_nxt.rresp = 2'b10;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_r          <= '0;
      s_r.phase    <= ST_IDLE;
      s_r.pf_words <= PF_WORDS_RESET;
      s_r.bf_words <= BF_WORDS_RESET;
      s_r.config_word_zero <= CFG0_DEFAULT;
      s_r.awready  <= 1'b1;
      s_r.wready   <= 1'b1;
      s_r.arready  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready_out = s_r.awready;
  assign s_axi_wready_out  = s_r.wready;
  assign s_axi_bvalid_out  = s_r.bvalid;
  assign s_axi_bresp_out   = s_r.bresp;
  assign s_axi_arready_out = s_r.arready;
  assign s_axi_rvalid_out  = s_r.rvalid;
  assign s_axi_rdata_out   = s_r.rdata;
  assign s_axi_rresp_out   = s_r.rresp;
  assign mem_addr_out      = s_r.mem_addr;
  assign mem_rd_out        = s_r.mem_rd;
  assign mem_region_out    = s_r.mem_region;

  // Result is zero when protected, else the complement of the total plus one.
  a_result_value: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(s_r.done) |-> (s_r.checksum == (s_r.protect ? 32'h0 : (~total + 32'h1))))
    else $error("checksum does not match the byte total");
  // Protected devices report zero.
  a_protect_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_r.done && s_r.protect) |-> s_r.checksum == 32'h0)
    else $error("protected device checksum not zero");
  // Program words add their byte sum into the program sum.
  a_prog_accum: assert property (@(posedge clk_in) disable iff (reset_in)
    (fifo_out_valid && fifo_out.region == REGION_PROGRAM) |=>
    s_r.pf_sum == $past(s_r.pf_sum) + byte_sum($past(fifo_out.data)))
    else $error("program sum not accumulated");
  // Configuration words never reach the boot sum.
  a_cfg_excluded: assert property (@(posedge clk_in) disable iff (reset_in)
    (fifo_out_valid && fifo_out.region == REGION_CONFIG) |=> $stable(s_r.bf_sum))
    else $error("configuration word added to boot sum");
  // Configuration word zero contributes only its masked bits.
  a_cfg0_mask: assert property (@(posedge clk_in) disable iff (reset_in)
    (fifo_out_valid && fifo_out.region == REGION_CONFIG && fifo_out.cfg_index == 2'd0) |=>
    s_r.cfg_sum == $past(s_r.cfg_sum) + byte_sum($past(fifo_out.data & masks.cfg0_mask)))
    else $error("configuration word zero mask not applied");
  // Identifier contributes only its masked bits.
  a_ident_mask: assert property (@(posedge clk_in) disable iff (reset_in)
    (fifo_out_valid && fifo_out.region == REGION_IDENT) |=>
    s_r.id_sum == $past(s_r.id_sum) + byte_sum($past(fifo_out.data & masks.id_mask)))
    else $error("identifier mask not applied");
  // Reference variant uses the documented configuration word zero mask.
  a_ref_mask: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_r.variant == 2'd2) |-> masks.cfg0_mask == 32'h110F_F00B)
    else $error("reference mask wrong");
  // A write response follows both write channels within one cycle.
  a_bus_write: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_r.aw_got && s_r.w_got && !s_r.bvalid) |=> s_r.bvalid)
    else $error("write response missing");
  // Byte sums never exceed four bytes per word.
  a_byte_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    fifo_out_valid |-> byte_sum(masked) <= 32'h3FC)
    else $error("byte sum exceeds four bytes");
endmodule // memory_image_checksum
`default_nettype wire

// ---- dv/flash_model.sv ----
// Behavioural flash arrays that answer the checksum engine's read port.
// Assumes the engine takes the word in the cycle in which its registered read strobe stands.
`timescale 1ns/1ps
`default_nettype none
package flash_image_pkg;
  import image_checksum_pkg::*;
  // Word held at one place; the top boot word is configuration word zero.
  function automatic logic [31:0] word_at(input region_t rg, input logic [31:0] a,
                                          input logic [31:0] bfw, input logic er, input logic pr);
    logic [31:0] w;
    w = er ? ERASED_WORD : (32'h9E37_79B9 * (a + 32'h1)) ^ 32'(rg);
    if (rg == REGION_BOOT && a == bfw - 32'h1) begin
      w = er ? CFG0_DEFAULT : w | 32'h1000_0000;
      if (pr) begin
        w = w & 32'hEFFF_FFFF;
      end
    end
    return w;
  endfunction
endpackage
module flash_model
  import flash_image_pkg::*;
(
  input  wire logic                        rd_in,
  input  wire logic [31:0]                 addr_in,
  input  wire image_checksum_pkg::region_t region_in,
  input  wire logic [31:0]                 bf_words_in,
  input  wire logic                        erased_in,
  input  wire logic                        prot_in,
  output logic      [31:0]                 rdata_out
);
  // The engine registers address and strobe, then takes the word before the next edge.
  // Between reads the inverse is shown, so a word taken in the wrong cycle never matches.
  assign rdata_out = rd_in ? word_at(region_in, addr_in, bf_words_in, erased_in, prot_in) :
                             ~word_at(region_in, addr_in, bf_words_in, erased_in, prot_in);
endmodule // flash_model
`default_nettype wire

// ---- dv/test_memory_image_checksum.sv ----
// Self-checking bench for the image checksum engine and its word buffer.
// Assumes the flash model answers reads and the bench masters AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_memory_image_checksum;
  import image_checksum_pkg::*;
  import flash_image_pkg::*;
  typedef struct { int pf; int bf; logic [1:0] v; logic er; logic [31:0] id; } row_t;
  logic        clk_in, reset_in, awvalid, wvalid, bready, arvalid, rready, erased, prot;
  logic        awready, wready, bvalid, arready, rvalid, mem_rd;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, mem_rdata, ident, bfw, d, sum;
  logic [31:0] e [4];
  logic [1:0]  bresp, rresp, rs;
  region_t     mem_region;
  int          err_count, n_compared;
  row_t        r;
  row_t        rows [5] = '{'{8, 8, 2'd2, 1'b1, 32'h0A5C_3E21}, '{1, 5, 2'd0, 1'b0, 32'hFFFF_FFFF},
                            '{9, 12, 2'd1, 1'b0, 32'h1234_5678}, '{3, 7, 2'd3, 1'b0, 32'hC0DE_F00D},
                            '{16, 20, 2'd2, 1'b0, 32'h8765_4321}};
  logic [7:0]  offs [4] = '{PF_SUM_OFFSET, BF_SUM_OFFSET, CFG_SUM_OFFSET, ID_SUM_OFFSET};
  memory_image_checksum dut (.clk_in(clk_in), .reset_in(reset_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .mem_addr_out(mem_addr), .mem_rd_out(mem_rd),
    .mem_region_out(mem_region), .mem_rdata_in(mem_rdata), .device_identifier_word_in(ident),
    .variant_in(2'b00));
  flash_model flash (.rd_in(mem_rd), .addr_in(mem_addr),
    .region_in(mem_region), .bf_words_in(bfw), .erased_in(erased), .prot_in(prot),
    .rdata_out(mem_rdata));
  // Free-running 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Sum of the four unsigned bytes of a word.
  function automatic logic [31:0] bs(input logic [31:0] w);
    return 32'(w[7:0]) + 32'(w[15:8]) + 32'(w[23:16]) + 32'(w[31:24]);
  endfunction
  // Expected region sums of one walk, from the byte rule and the mask table.
  task automatic calc(input int pf, input int bf, input logic [1:0] v, input logic er,
                      input logic [31:0] id);
    e = '{default: 32'h0};
    for (int a = 0; a < pf; a++) e[0] += bs(word_at(REGION_PROGRAM, a, bf, er, 1'b0));
    for (int a = 0; a < bf - 4; a++) e[1] += bs(word_at(REGION_BOOT, a, bf, er, 1'b0));
    for (int c = 0; c < CFG_WORD_COUNT; c++) begin
      e[2] += bs(word_at(REGION_BOOT, bf - 1 - c, bf, er, 1'b0) &
                 MASK_TABLE[v][32*c +: 32]);
    end
    e[3] = bs(id & MASK_TABLE[v][128 +: 32]);
    sum = e[0] + e[1] + e[2] + e[3];
  endtask
  // One AXI4-Lite write; address and data are each released once taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rr);
    int n;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rr = bresp;
    bready <= 1'b0;
    if (n == 100) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // One AXI4-Lite read.
  task automatic axr(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
    int n;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (n == 100) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // Polls status until a walk has been seen busy and then done.
  task automatic wait_done();
    logic [31:0] st;
    logic [1:0]  q;
    bit          seen;
    int          n;
    seen = 0;
    for (n = 0; n < 3000; n++) begin
      axr(STATUS_OFFSET, st, q);
      if (st[STATUS_BUSY_BIT] === 1'b1) seen = 1;
      if (seen && st[STATUS_DONE_BIT] === 1'b1 && st[STATUS_BUSY_BIT] === 1'b0) break;
    end
    if (n == 3000) begin
      err_count++;
      report_and_stop();
    end
  endtask
  // Main sequence: table rows, then reset, busy, protect and unmapped cases.
  initial begin
    reset_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, erased, prot} = 7'h00;
    {awaddr, araddr, wdata, ident, bfw} = '0;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      erased <= r.er;
      ident <= r.id;
      bfw <= 32'(r.bf);
      calc(r.pf, r.bf, r.v, r.er, r.id);
      axw(PF_WORDS_OFFSET, 32'(r.pf), rs);
      axw(BF_WORDS_OFFSET, 32'(r.bf), rs);
      axw(CTRL_OFFSET, (32'(r.v) << CTRL_VARIANT_LSB) | 32'h1, rs);
      wait_done();
      axr(CHECKSUM_OFFSET, d, rs);
      `CHK(d, ~sum + 32'h1)
      for (int q = 0; q < 4; q++) begin
        axr(offs[q], d, rs);
        `CHK(d, e[q])
        if (i == 0 && q == 2) `CHK(d, 32'h0000_05D4)
      end
      axr(CFG0_OFFSET, d, rs);
      `CHK(d, word_at(REGION_BOOT, r.bf - 1, r.bf, r.er, 1'b0))
      $display("table row %0d done", i);
    end
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    axr(PF_WORDS_OFFSET, d, rs);
    `CHK(d, PF_WORDS_RESET)
    axr(BF_WORDS_OFFSET, d, rs);
    `CHK(d, BF_WORDS_RESET)
    $display("reset values done");
    bfw <= 32'd8;
    calc(40, 8, 2'd2, erased, ident);
    axw(PF_WORDS_OFFSET, 32'd40, rs);
    axw(BF_WORDS_OFFSET, 32'd8, rs);
    axw(CTRL_OFFSET, 32'h0000_0021, rs);
    axw(PF_WORDS_OFFSET, 32'd3, rs);
    wait_done();
    axr(PF_WORDS_OFFSET, d, rs);
    `CHK(d, 32'd40)
    axr(CHECKSUM_OFFSET, d, rs);
    `CHK(d, ~sum + 32'h1)
    for (int q = 0; q < 4; q++) begin
      axr(offs[q], d, rs);
      `CHK(d, e[q])
    end
    axr(STATUS_OFFSET, d, rs);
    `CHK(d[2:0], 3'b010)
    $display("busy write done");
    prot <= 1'b1;
    axw(CTRL_OFFSET, 32'h0000_0021, rs);
    wait_done();
    axr(CHECKSUM_OFFSET, d, rs);
    `CHK(d, ZERO_WORD)
    axr(STATUS_OFFSET, d, rs);
    `CHK(d[STATUS_PROT_BIT], 1'b1)
    $display("protect done");
    axw(8'h3C, 32'h1, rs);
    `CHK(rs, 2'b10)
    axr(8'h3C, d, rs);
    `CHK({d, rs}, {ZERO_WORD, 2'b10})
    $display("unmapped done");
    report_and_stop();
  end
endmodule // test_memory_image_checksum
`default_nettype wire
